// ==== src/fskm_core.sv ====
// Digital core of a half-duplex FSK powerline modem with its host link.
// Line side is a square tone out and a comparator bit in; the analog
// amplifier and filters sit outside. All inputs but clk and rst pass through a synchroniser here.
`timescale 1ns/1ps
module fskm_core #(
    parameter int CLK_HZ = fskm_pkg::CLK_HZ,
    parameter int HOST_RST_CYC =
        fskm_pkg::CLK_HZ / 1_000_000 * fskm_pkg::HOST_RST_TIME_US,
    parameter int TX_TOUT_CYC =
        fskm_pkg::CLK_HZ / 1000 * fskm_pkg::TX_TOUT_TIME_MS,
    parameter int WDOG_CYC = fskm_pkg::CLK_HZ / 1000 * fskm_pkg::WDOG_TIME_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host data link
    input wire logic direction_select,
    input wire logic host_txd,
    output logic host_rxd,
    output logic bit_clock_line,
    input wire logic uart_mode,
    // Host configuration port
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    // Host support
    output logic host_reset_out_n,
    output logic mclk_out,
    // Line side
    output logic amplifier_out,
    output logic tx_active,
    input wire logic line_in,
    input wire logic thermal_alarm,
    // Status
    output logic carrier_detect,
    output logic band_in_use,
    output logic preamble_found,
    output logic header_found,
    output logic tx_timeout,
    output logic thermal_shutdown
);
    import fskm_pkg::*;

    localparam int PW = 16;

    if (CLK_HZ < 1_000_000 || CLK_HZ / 600 > 65535 ||
        HOST_RST_CYC < 1 || TX_TOUT_CYC < 1 || WDOG_CYC < 1) begin : g_chk
        $error("fskm_core: clock rate or timing count out of range");
    end

    // Synchronised pins
    logic [7:0] pins_s;
    logic dir_s, txd_s, uart_s, cs_n_s, sclk_s, mosi_s, line_s, therm_s;

    // Receive, idle data and deselected port after reset
    fskm_sync #(.W(8), .INIT(8'hD0)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({direction_select, host_txd, uart_mode, spi_cs_n, spi_sclk,
            spi_mosi, line_in, thermal_alarm}),
        .q(pins_s)
    );
    assign {dir_s, txd_s, uart_s, cs_n_s, sclk_s, mosi_s, line_s, therm_s} =
        pins_s;

    // Channel and rate tables
    logic [NCO_W-1:0] ch_inc [8];
    logic [PW-1:0] ch_per [8];
    logic [NCO_W-1:0] dv_inc [4];
    logic [PW-1:0] bit_cyc [4];

    for (genvar i = 0; i < 8; i++) begin : g_ch
        assign ch_inc[i] = NCO_W'((64'(chan_hz(i)) << NCO_W) / CLK_HZ);
        assign ch_per[i] = PW'(CLK_HZ / chan_hz(i));
    end
    for (genvar j = 0; j < 4; j++) begin : g_rate
        assign dv_inc[j] = NCO_W'((64'(baud_hz(j)) << (NCO_W - 1)) / CLK_HZ);
        assign bit_cyc[j] = PW'(CLK_HZ / baud_hz(j));
    end

    logic [CFG_W-1:0] cfg_q;
    logic [CFG_CHAN_W-1:0] chan;
    logic [CFG_BAUD_W-1:0] baud;
    logic [PW-1:0] per_nom, cyc_bit, cyc_half;
    logic [NCO_W-1:0] dev;

    assign chan = cfg_q[CFG_CHAN_LSB +: CFG_CHAN_W];
    assign baud = cfg_q[CFG_BAUD_LSB +: CFG_BAUD_W];
    assign per_nom = ch_per[chan];
    assign cyc_bit = bit_cyc[baud];
    assign cyc_half = cyc_bit >> 1;
    assign dev = cfg_q[CFG_DEV_HALF_BIT] ? (dv_inc[baud] >> 1) : dv_inc[baud];

    // Edge detection on synchronised pins
    logic dir_d_q, sclk_d_q, cs_d_q, line_d_q;
    logic dir_chg, sclk_rise, cs_fall, cs_rise, line_rise;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_d_q <= 1'b1;
            sclk_d_q <= 1'b0;
            cs_d_q <= 1'b1;
            line_d_q <= 1'b0;
        end else begin
            dir_d_q <= dir_s;
            sclk_d_q <= sclk_s;
            cs_d_q <= cs_n_s;
            line_d_q <= line_s;
        end
    end
    assign dir_chg = dir_s ^ dir_d_q;
    assign sclk_rise = sclk_s & ~sclk_d_q;
    assign cs_fall = ~cs_n_s & cs_d_q;
    assign cs_rise = cs_n_s & ~cs_d_q;
    assign line_rise = line_s & ~line_d_q;

    // Configuration port
    logic [CFG_W-1:0] shift_q;
    logic [5:0] sbits_q;
    logic cfg_wr;

    assign cfg_wr = cs_rise & ~uart_s & (sbits_q == 6'(CFG_W));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_q <= '0;
            sbits_q <= '0;
            spi_miso <= 1'b0;
            cfg_q <= CFG_RESET;
        end else begin
            if (cs_fall) begin
                shift_q <= cfg_q;
                sbits_q <= '0;
            end else if (sclk_rise && !cs_n_s) begin
                shift_q <= {shift_q[CFG_W-2:0], mosi_s};
                if (sbits_q != 6'(CFG_W)) begin
                    sbits_q <= sbits_q + 6'h01;
                end
            end
            spi_miso <= ~uart_s & ~cs_n_s & shift_q[CFG_W-1];
            if (cfg_wr) begin
                cfg_q <= shift_q;
            end
        end
    end

    // Host reset and watchdog
    logic [31:0] rst_cnt_q, wdog_cnt_q;
    logic wdog_fire;

    assign wdog_fire = cfg_q[CFG_WDOG_EN_BIT] &&
                       (wdog_cnt_q == 32'(WDOG_CYC - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdog_cnt_q <= '0;
        end else if (cfg_wr || wdog_fire || !cfg_q[CFG_WDOG_EN_BIT]) begin
            wdog_cnt_q <= '0;
        end else begin
            wdog_cnt_q <= wdog_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_cnt_q <= '0;
            host_reset_out_n <= 1'b0;
        end else if (wdog_fire) begin
            rst_cnt_q <= '0;
            host_reset_out_n <= 1'b0;
        end else if (rst_cnt_q != 32'(HOST_RST_CYC - 1)) begin
            rst_cnt_q <= rst_cnt_q + 32'h1;
            host_reset_out_n <= 1'b0;
        end else begin
            host_reset_out_n <= 1'b1;
        end
    end

    logic [3:0] mdiv_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mdiv_q <= '0;
            mclk_out <= 1'b0;
        end else begin
            mdiv_q <= mdiv_q + 4'h1;
            mclk_out <= mdiv_q[cfg_q[CFG_MCLK_LSB +: CFG_MCLK_W]];
        end
    end

    // Bit timer, shared by both directions
    logic [PW-1:0] ph_q;
    logic bit_wrap, dbit_q, dbit_prev_q;

    assign bit_wrap = (ph_q >= cyc_bit - 16'h0001);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_q <= '0;
        end else if (dir_s && (dbit_q != dbit_prev_q)) begin
            ph_q <= cyc_half;
        end else if (bit_wrap || dir_chg) begin
            ph_q <= '0;
        end else begin
            ph_q <= ph_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_clock_line <= 1'b0;
        end else begin
            bit_clock_line <= ~uart_s & (ph_q < cyc_half);
        end
    end

    // Transmit path
    logic [31:0] tout_cnt_q;
    logic tx_bit_q, tx_on;
    logic [NCO_W-1:0] nco_q;

    assign tx_on = ~dir_s & ~tx_timeout & ~thermal_shutdown;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tout_cnt_q <= '0;
            tx_timeout <= 1'b0;
            thermal_shutdown <= 1'b0;
        end else begin
            thermal_shutdown <= therm_s;
            if (dir_s || !cfg_q[CFG_TOUT_EN_BIT]) begin
                tout_cnt_q <= '0;
                tx_timeout <= 1'b0;
            end else if (tout_cnt_q == 32'(TX_TOUT_CYC - 1)) begin
                tx_timeout <= 1'b1;
            end else begin
                tout_cnt_q <= tout_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_bit_q <= 1'b1;
            nco_q <= '0;
            amplifier_out <= 1'b0;
            tx_active <= 1'b0;
        end else begin
            if (bit_wrap || dir_chg) begin
                tx_bit_q <= txd_s;
            end
            if (tx_on) begin
                nco_q <= tx_bit_q ? nco_q + ch_inc[chan] + dev
                                  : nco_q + ch_inc[chan] - dev;
            end else begin
                nco_q <= '0;
            end
            amplifier_out <= tx_on & nco_q[NCO_W-1];
            tx_active <= tx_on;
        end
    end

    // Receive demodulator: period between rising zero crossings
    logic [PW-1:0] pcnt_q, pdiff;
    logic [4:0] band_cnt_q;
    logic in_band;

    assign pdiff = (pcnt_q > per_nom) ? pcnt_q - per_nom : per_nom - pcnt_q;
    assign in_band = (pdiff < (per_nom >> 2));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcnt_q <= '0;
            dbit_q <= 1'b1;
            dbit_prev_q <= 1'b1;
        end else begin
            dbit_prev_q <= dbit_q;
            if (!dir_s || line_rise) begin
                pcnt_q <= '0;
            end else if (pcnt_q != 16'hFFFF) begin
                pcnt_q <= pcnt_q + 16'h0001;
            end
            if (dir_s && line_rise && in_band) begin
                dbit_q <= (pcnt_q < per_nom);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carrier_detect <= 1'b0;
            band_in_use <= 1'b0;
            band_cnt_q <= '0;
        end else if (!dir_s || (pcnt_q > (per_nom << 1)) ||
                     (line_rise && !in_band)) begin
            carrier_detect <= 1'b0;
            band_in_use <= 1'b0;
            band_cnt_q <= '0;
        end else if (line_rise) begin
            carrier_detect <= 1'b1;
            if (band_cnt_q == 5'(BAND_EDGES - 1)) begin
                band_in_use <= 1'b1;
            end else begin
                band_cnt_q <= band_cnt_q + 5'h01;
            end
        end
    end

    // Received bits, preamble and header search
    logic [CFG_HDR_W-1:0] rx_sh_q;
    logic [CFG_HDR_W-1:0] hdr;
    logic hdr_hit;

    assign hdr = cfg_q[CFG_HDR_LSB +: CFG_HDR_W];
    assign hdr_hit = cfg_q[CFG_HDR16_BIT] ? (rx_sh_q == hdr)
                                          : (rx_sh_q[7:0] == hdr[7:0]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_rxd <= 1'b1;
            rx_sh_q <= '0;
            preamble_found <= 1'b0;
            header_found <= 1'b0;
        end else if (!dir_s || dir_chg) begin
            host_rxd <= 1'b1;
            rx_sh_q <= '0;
            preamble_found <= 1'b0;
            header_found <= 1'b0;
        end else if (bit_wrap) begin
            host_rxd <= dbit_q;
            rx_sh_q <= {rx_sh_q[CFG_HDR_W-2:0], dbit_q};
            if (cfg_q[CFG_PRE_EN_BIT] && carrier_detect &&
                (rx_sh_q[3:0] == 4'h5 || rx_sh_q[3:0] == 4'hA)) begin
                preamble_found <= 1'b1;
            end
            if (hdr_hit) begin
                header_found <= 1'b1;
            end
        end
    end
endmodule // fskm_core

// ==== src/fskm_pkg.sv ====
// Constants, configuration layout and channel tables of the FSK modem core.
// Assumes a single system clock; all tables are folded at elaboration.
package fskm_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam int NCO_W = 24;
    localparam int CFG_W = 32;

    // Configuration field positions
    localparam int CFG_CHAN_LSB = 0;
    localparam int CFG_CHAN_W = 3;
    localparam int CFG_BAUD_LSB = 3;
    localparam int CFG_BAUD_W = 2;
    localparam int CFG_DEV_HALF_BIT = 5;
    localparam int CFG_PRE_EN_BIT = 6;
    localparam int CFG_HDR16_BIT = 7;
    localparam int CFG_WDOG_EN_BIT = 8;
    localparam int CFG_TOUT_EN_BIT = 9;
    localparam int CFG_MCLK_LSB = 10;
    localparam int CFG_MCLK_W = 2;
    localparam int CFG_HDR_LSB = 16;
    localparam int CFG_HDR_W = 16;
    localparam logic [CFG_W-1:0] CFG_RESET = 32'h9B58_0012;

    // Timing in their own units
    localparam int HOST_RST_TIME_US = 1000;
    localparam int TX_TOUT_TIME_MS = 1000;
    localparam int WDOG_TIME_MS = 1500;
    localparam int BAND_EDGES = 16;

    function automatic int chan_hz(input int idx);
        case (idx)
            0: chan_hz = 60000;
            1: chan_hz = 66000;
            2: chan_hz = 72000;
            3: chan_hz = 76000;
            4: chan_hz = 82050;
            5: chan_hz = 86000;
            6: chan_hz = 110000;
            default: chan_hz = 132500;
        endcase
    endfunction

    function automatic int baud_hz(input int idx);
        case (idx)
            0: baud_hz = 600;
            1: baud_hz = 1200;
            2: baud_hz = 2400;
            default: baud_hz = 4800;
        endcase
    endfunction

endpackage

// ==== src/fskm_sync.sv ====
// Two-stage synchroniser for a group of asynchronous level inputs.
// Each bit is crossed on its own; no relation between bits is kept.
`timescale 1ns/1ps
module fskm_sync #(
    parameter int W = 1,
    // Idle level of each pin, so that leaving reset shows no false edge
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // fskm_sync

// ==== tb/fskm_core_sva.sv ====
// Port-level checker for the modem core.
// Assumes it is bound to fskm_core with the same reset length.
`timescale 1ns/1ps
module fskm_chk #(
    parameter int HOST_RST_CYC = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins from the host and the line
    input wire logic direction_select,
    input wire logic uart_mode,
    input wire logic thermal_alarm,
    // Outputs under watch
    input wire logic host_rxd,
    input wire logic bit_clock_line,
    input wire logic spi_miso,
    input wire logic host_reset_out_n,
    input wire logic mclk_out,
    input wire logic amplifier_out,
    input wire logic tx_active,
    input wire logic tx_timeout,
    input wire logic thermal_shutdown
);
    int lo_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Low time of the host reset pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_q <= 0;
        end else begin
            lo_q <= host_reset_out_n ? 0 : lo_q + 1;
        end
    end
    // Six samples cover the two-stage pin synchroniser
    property p_duplex;
        direction_select [*6] |-> !tx_active;
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("transmitter on while receiving");
    property p_amp_idle;
        !tx_active [*4] |-> !amplifier_out;
    endproperty
    a_amp_idle: assert property (p_amp_idle)
        else $error("tone out while transmitter off");
    property p_uart_clk;
        uart_mode [*6] |-> !bit_clock_line;
    endproperty
    a_uart_clk: assert property (p_uart_clk)
        else $error("bit clock runs in uart mode");
    property p_uart_miso;
        uart_mode [*6] |-> !spi_miso;
    endproperty
    a_uart_miso: assert property (p_uart_miso)
        else $error("config port answers in uart mode");
    property p_rx_idle;
        !direction_select [*6] |-> host_rxd;
    endproperty
    a_rx_idle: assert property (p_rx_idle)
        else $error("receive data not idle in transmit");
    property p_therm;
        thermal_alarm [*6] |-> thermal_shutdown && !tx_active;
    endproperty
    a_therm: assert property (p_therm)
        else $error("no shutdown on overtemperature");
    property p_tout;
        tx_timeout [*2] |-> !tx_active;
    endproperty
    a_tout: assert property (p_tout)
        else $error("transmitter on after time-out");
    property p_rst_max;
        !host_reset_out_n |-> lo_q <= HOST_RST_CYC + 1;
    endproperty
    a_rst_max: assert property (p_rst_max)
        else $error("host reset held too long");
    property p_rst_min;
        $rose(host_reset_out_n) |-> lo_q >= HOST_RST_CYC - 2;
    endproperty
    a_rst_min: assert property (p_rst_min)
        else $error("host reset pulse too short");
    property p_mclk;
        1'b1 |-> ##[1:17] (mclk_out != $past(mclk_out));
    endproperty
    a_mclk: assert property (p_mclk)
        else $error("host clock stalled");
endmodule // fskm_chk

// ==== tb/fskm_host.sv ====
// Host model: configuration port master, mode 0, 800 ns bit time.
// Assumes it is called just after a rising clock edge.
`timescale 1ns/1ps
module fskm_host (
    // Clock
    input wire logic clk,
    // Serial port
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    task automatic xfer(input logic [31:0] wr, output logic [31:0] rd);
        for (int i = 31; i >= 0; i--) begin
            spi_mosi <= wr[i];
            spi_cs_n <= 1'b0;
            repeat (i == 31 ? 8 : 4) @(posedge clk);
            rd[i] = spi_miso;
            spi_sclk <= 1'b1;
            repeat (4) @(posedge clk);
            spi_sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        spi_cs_n <= 1'b1;
        // Deselected data line must not look like a held bit
        spi_mosi <= ~wr[0];
        repeat (8) @(posedge clk);
    endtask
endmodule // fskm_host

// ==== tb/tb_top.sv ====
// Self-checking bench for the modem core.
// Assumes a 2 MHz core rate setting to keep bit times short.
`timescale 1ns/1ps
module tb_top;
    import fskm_pkg::*;
    localparam int CK = 2_000_000;
    logic clk, rst, direction_select, host_txd, uart_mode;
    logic thermal_alarm, line_in, spi_cs_n, spi_sclk, spi_mosi, spi_miso;
    logic host_rxd, bit_clock_line, host_reset_out_n, mclk_out;
    logic amplifier_out, tx_active, carrier_detect, band_in_use;
    logic preamble_found, header_found, tx_timeout, thermal_shutdown;
    logic bc_d, cap;
    logic [31:0] rd, cfg;
    logic q[$];
    int err_total, total_checks, cyc, seed, p, c, f, k;
    int bauds[4] = '{600, 1200, 2400, 4800};
    int chans[8] = '{60000, 66000, 72000, 76000, 82050, 86000, 110000, 132500};
    fskm_core #(.CLK_HZ(CK), .HOST_RST_CYC(20), .TX_TOUT_CYC(200),
        .WDOG_CYC(600)) dut (.*);
    fskm_host host (.*);
    always #50 clk = ~clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        bc_d <= bit_clock_line;
        if (cap && bit_clock_line && !bc_d) q.push_back(host_rxd);
        cyc++;
        if (cyc == 95000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %0h got %0h", n, e, g);
        end
    endtask
    task automatic near(string n, int e, int g);
        chk(n, e, (g >= e - 1 && g <= e + 1) ? e : g);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wcfg(logic [31:0] v);
        host.xfer(v, rd);
        chk("cfg_rd", cfg, rd);
        cfg = v;
    endtask
    // Edges from one rise to the next
    task automatic per(int sel, output int p);
        logic a, b;
        p = 0;
        a = 1'b1;
        for (int e = 0; e < 2 && p < 9000;) begin
            b = a;
            @(posedge clk);
            a = sel ? bit_clock_line : mclk_out;
            if (e == 1) p++;
            if (a === 1'b1 && b === 1'b0) e++;
        end
    endtask
    task automatic amp(int n, output int c);
        logic b;
        c = 0;
        repeat (n) begin
            b = amplifier_out;
            @(posedge clk);
            if (amplifier_out === 1'b1 && b === 1'b0) c++;
        end
    endtask
    // Line tone: short period for 1, long for 0 around 27 cycles
    task automatic lbit(logic v);
        for (int t = 0; t < 416; t += v ? 23 : 32) begin
            line_in <= 1'b1;
            tick(v ? 11 : 16);
            line_in <= 1'b0;
            tick(v ? 12 : 16);
        end
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        direction_select = 1'b1;
        host_txd = 1'b1;
        uart_mode = 1'b0;
        thermal_alarm = 1'b0;
        line_in = 1'b0;
        cap = 1'b0;
        seed = 65669;
        cfg = CFG_RESET;
        tick(12);
        rst <= 1'b0;
        tick(3);
        chk("host_reset_out_lo", 0, host_reset_out_n);
        tick(25);
        chk("host_reset_out_hi", 1, host_reset_out_n);
        chk("rxd_idle", 1, host_rxd);
        $display("reset test done");
        uart_mode <= 1'b1;
        tick(4);
        host.xfer(32'h0000_0C00, rd);
        chk("miso_uart", 0, rd);
        uart_mode <= 1'b0;
        tick(4);
        k = $random(seed);
        wcfg({k[15:0], 16'h0018});
        wcfg({k[15:0], 16'h0018});
        for (int d = 0; d < 4; d++) begin
            wcfg(cfg & 32'hFFFF_F3FF | (d << 10));
            per(0, p);
            chk("mclk_per", 2 << d, p);
        end
        direction_select <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            wcfg(cfg & 32'hFFFF_FFE7 | (b << 3));
            per(1, p);
            near("bit_per", CK / bauds[b], p);
        end
        $display("clock test done");
        for (int i = 0; i < 8; i++) begin
            wcfg(cfg & 32'hFFFF_FFF8 | i);
            amp(2000, c);
            near("tone", (chans[i] + 2900) / 1000, c);
        end
        for (int i = 0; i < 4; i++) begin
            k = $random(seed);
            host_txd <= k[0] ^ i[1];
            wcfg(cfg & 32'hFFFF_FFD8 | 2 | (i[0] << 5));
            tick(900);
            amp(5000, c);
            f = 2400 >> i[0];
            f = 72000 + (host_txd ? f : -f);
            near("dev", (f * 5000 + CK / 2) / CK, c);
        end
        thermal_alarm <= 1'b1;
        tick(8);
        chk("therm", 1, thermal_shutdown);
        thermal_alarm <= 1'b0;
        tick(8);
        chk("tx_on", 1, tx_active);
        wcfg(cfg | 32'h0000_0200);
        tick(220);
        chk("tout", 1, tx_timeout);
        direction_select <= 1'b1;
        tick(8);
        chk("tout_clr", 0, tx_timeout);
        $display("transmit test done");
        wcfg({cfg[31:24], 8'h55, 16'h005A});
        cap <= 1'b1;
        for (int i = 0; i < 16; i++) lbit(i[0]);
        chk("hdr", 1, header_found);
        chk("carrier", 1, carrier_detect);
        chk("band", 1, band_in_use);
        chk("pre", 1, preamble_found);
        chk("rx_alt", q[$] ^ 1'b1, q[$-1]);
        for (int i = 0; i < 8; i++) lbit(1'b1);
        chk("rx_one", 1, q[$]);
        line_in <= 1'b0;
        tick(80);
        chk("no_car", 0, carrier_detect);
        $display("receive test done");
        wcfg(cfg | 32'h0000_0100);
        for (k = 0; host_reset_out_n === 1'b1 && k < 900; k++) tick(1);
        chk("wdog", 1, k > 560 && k < 620);
        tick(25);
        chk("host_reset_out_back", 1, host_reset_out_n);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(4);
        host.xfer(32'h0, rd);
        chk("cfg_rst", CFG_RESET, rd);
        $display("watchdog test done");
        summarize();
    end
endmodule // tb_top
bind fskm_core fskm_chk #(.HOST_RST_CYC(HOST_RST_CYC)) u_chk (.*);
